// ==== shared/pef_map.svh ====
/*
 * Constants of the progress event packet framer: packet field values,
 * register offsets, reset values and bit positions.
 * Assumes inclusion by bare name from package and design files.
 */
`ifndef PEF_MAP_SVH
`define PEF_MAP_SVH

// constant packet header fields
`define PEF_VERSION        3'h0
`define PEF_PKT_TYPE_BIT   1'h0
`define PEF_SEC_HDR_FLAG   1'h1
`define PEF_APID           7'h47
`define PEF_CATEGORY       4'h7
`define PEF_SEG_FLAGS      2'h3
`define PEF_PAYLOAD_BYTES  16'h0002
`define PEF_LEN_EXTRA      16'h0009
`define PEF_SERVICE_VER    3'h2
`define PEF_CHECKSUM_FLAG  1'h0
`define PEF_SPARE          4'h0
`define PEF_SERVICE_TYPE   8'h05
`define PEF_SUBTYPE_DEF    8'h01
`define PEF_PAD            8'h00
`define PEF_EVID_POWERUP   16'hA7FE
`define PEF_EVID_ASTEROID  16'hA7FF
`define PEF_PKT_BYTES      5'h12
`define PEF_SEQ_RESET      14'h0000

// register byte offsets
`define PEF_REG_CTRL       8'h00
`define PEF_REG_STATUS     8'h04
`define PEF_REG_IRQ_STAT   8'h08
`define PEF_REG_IRQ_MASK   8'h0C
`define PEF_REG_SEQ        8'h10
`define PEF_REG_SUBTYPE    8'h14
`define PEF_REG_SECONDS    8'h18
`define PEF_REG_FRACTION   8'h1C

// control bits
`define PEF_CTRL_BOOT_OK   0
`define PEF_CTRL_SYNC_TC   1
`define PEF_CTRL_AST_GO    2
`define PEF_CTRL_ENABLE    3

// status bits
`define PEF_ST_BUSY        0
`define PEF_ST_PWR_SENT    1
`define PEF_ST_SYNC_PEND   2

// interrupt bits
`define PEF_IRQ_PWR_DONE   0
`define PEF_IRQ_AST_DONE   1
`define PEF_IRQ_AST_DROP   2

`endif

// ==== shared/pef_pkg.sv ====
/*
 * Types of the progress event packet framer.
 * Assumes pef_map.svh for field widths and values.
 */
`include "pef_map.svh"

package pef_pkg;

	// primary header, 6 bytes
	typedef struct packed {
		logic [2:0]  version;
		logic        pkt_type;
		logic        sec_hdr_flag;
		logic [6:0]  apid;
		logic [3:0]  category;
		logic [1:0]  seg_flags;
		logic [13:0] seq_count;
		logic [15:0] length;
	} pef_prim_hdr_t;

	// secondary header, 10 bytes
	typedef struct packed {
		logic [31:0] seconds;
		logic [15:0] fraction;
		logic        spare_msb;
		logic [2:0]  service_ver;
		logic        checksum_flag;
		logic [2:0]  spare_lsb;
		logic [7:0]  service_type;
		logic [7:0]  subtype;
		logic [7:0]  pad;
	} pef_sec_hdr_t;

	// whole packet, 18 bytes
	typedef struct packed {
		pef_prim_hdr_t prim;
		pef_sec_hdr_t  sec;
		logic [15:0]   event_id;
	} pef_packet_t;

	// serialiser states
	typedef enum logic [2:0] {
		PEF_IDLE = 3'b001,
		PEF_SEND = 3'b010,
		PEF_DONE = 3'b100
	} pef_state_t;

endpackage

// ==== logic/pef_byte_ser.sv ====
/*
 * Byte serialiser: shifts a latched packet out most significant byte first
 * with valid/ready handshake.
 * Assumes one clock, synchronous active-high reset, a sink that may stall.
 */
`timescale 1ns/1ns
`include "pef_map.svh"

module pef_byte_ser (
	input  wire logic                  clk_i,
	input  wire logic                  rst_i,
	input  wire logic                  start_i,
	input  wire pef_pkg::pef_packet_t  pkt_i,
	output logic                       busy_o,
	output logic                       done_o,
	output logic [7:0]                 data_o,
	output logic                       valid_o,
	output logic                       last_o,
	input  wire logic                  ready_i
);

	pef_pkg::pef_state_t state_r, state_nxt;
	logic [143:0]        shreg_r, shreg_nxt;
	logic [4:0]          left_r, left_nxt;
	logic                last_r, last_nxt;

	// next state: load on start, shift on each accepted byte
	always_comb begin
		state_nxt = state_r;
		shreg_nxt = shreg_r;
		left_nxt  = left_r;
		case (state_r)
			pef_pkg::PEF_IDLE: begin
				if (start_i) begin
					shreg_nxt = pkt_i;
					left_nxt  = `PEF_PKT_BYTES;
					state_nxt = pef_pkg::PEF_SEND;
				end
			end
			pef_pkg::PEF_SEND: begin
				if (ready_i) begin
					shreg_nxt = {shreg_r[135:0], 8'h00};
					left_nxt  = left_r - 5'h01;
					if (left_r == 5'h01) begin
						state_nxt = pef_pkg::PEF_DONE;
					end
				end
			end
			pef_pkg::PEF_DONE: begin
				state_nxt = pef_pkg::PEF_IDLE;
			end
			default: begin
				state_nxt = pef_pkg::PEF_IDLE;
			end
		endcase
		// last flag prepared one cycle ahead so the pin comes from a flop
		last_nxt = (state_nxt == pef_pkg::PEF_SEND) && (left_nxt == 5'h01);
	end

	// register state
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_r <= pef_pkg::PEF_IDLE;
			shreg_r <= 144'h0;
			left_r  <= 5'h00;
			last_r  <= 1'h0;
		end else begin
			state_r <= state_nxt;
			shreg_r <= shreg_nxt;
			left_r  <= left_nxt;
			last_r  <= last_nxt;
		end
	end

	// outputs straight from state
	assign data_o  = shreg_r[143:136];
	assign valid_o = state_r[1];         // one-hot send bit
	assign last_o  = last_r;
	assign busy_o  = (state_r != pef_pkg::PEF_IDLE);
	assign done_o  = (state_r == pef_pkg::PEF_DONE);

endmodule

// ==== logic/pef_framer.sv ====
/*
 * Progress event packet framer: builds powered-up and asteroid-started event
 * packets and streams them out bytewise, with a classic Wishbone register
 * slave, sticky interrupt status and a level interrupt.
 * Assumes one 10 MHz clock, synchronous active-high reset, a time sync pulse
 * from outside the clock domain and a byte sink with ready back-pressure.
 */
// Overview of operation
// - Every packet carries application process identifier 71 and category 7.
// - A 14-bit sequence count for this identifier/category starts at zero, +1 per packet.
// - The length field is payload bytes plus nine, so eleven for two bytes.
// - The secondary header holds a 48-bit start time, 4 bytes seconds then 2 fraction.
// - The service version field is binary 010 in every packet.
// - The service type field is 5 (event) in every packet.
// - Each packet ends in a two-byte source data field with the event identifier.
// - The powered-up event carries identifier 43006 (A7FE).
// - Powered-up goes out once, after boot completes, sync command and sync pulse.
// - Asteroid-started goes out when the asteroid mode sequence begins.
// - Asteroid start is expected to match the commanded start time; not checked.
// - The asteroid-started event carries identifier 43007 (A7FF).
`timescale 1ns/1ns
`include "pef_map.svh"

module pef_framer (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic [31:0]      wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        time_sync_pulse_i,
	output logic [7:0]       tm_data_o,
	output logic             tm_valid_o,
	output logic             tm_last_o,
	input  wire logic        tm_ready_i,
	output logic             irq_o
);

	// register state
	logic [3:0]  ctrl_r, ctrl_nxt;
	logic [2:0]  irq_stat_r, irq_stat_nxt;
	logic [2:0]  irq_mask_r, irq_mask_nxt;
	logic [7:0]  subtype_r, subtype_nxt;
	logic [31:0] seconds_r, seconds_nxt;
	logic [15:0] fraction_r, fraction_nxt;
	logic [13:0] seq_r, seq_nxt;
	logic        pwr_sent_r, pwr_sent_nxt;
	logic        pulse_seen_r, pulse_seen_nxt;
	logic        ast_pend_r, ast_pend_nxt;
	logic        start_r, start_nxt;
	logic        kind_ast_r, kind_ast_nxt;
	logic        ack_r, ack_nxt;
	logic [31:0] rdat_r, rdat_nxt;
	logic        irq_r, irq_nxt;
	logic [1:0]  sync_r;
	logic        pulse_d_r;

	// serialiser signals
	pef_pkg::pef_packet_t pkt;
	logic        ser_busy;
	logic        ser_done;
	logic [7:0]  ser_data;
	logic        ser_valid;
	logic        ser_last;
	logic        access;
	logic        wr;
	logic [31:0] wmask;
	logic        pulse_rise;

	// sync pulse: two flip-flops, edge taken from the second stage only
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sync_r    <= 2'h0;
			pulse_d_r <= 1'h0;
		end else begin
			sync_r    <= {sync_r[0], time_sync_pulse_i};
			pulse_d_r <= sync_r[1];
		end
	end
	assign pulse_rise = sync_r[1] & ~pulse_d_r;

	// bus decode
	assign access = wb_cyc_i & wb_stb_i & ~ack_r;
	assign wr     = access & wb_we_i;
	assign wmask  = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

	// packet assembly from constants, counter and time registers
	always_comb begin
		pkt.prim.version       = `PEF_VERSION;
		pkt.prim.pkt_type      = `PEF_PKT_TYPE_BIT;
		pkt.prim.sec_hdr_flag  = `PEF_SEC_HDR_FLAG;
		pkt.prim.apid          = `PEF_APID;
		pkt.prim.category      = `PEF_CATEGORY;
		pkt.prim.seg_flags     = `PEF_SEG_FLAGS;
		pkt.prim.seq_count     = seq_r;
		pkt.prim.length        = `PEF_PAYLOAD_BYTES + `PEF_LEN_EXTRA;
		pkt.sec.seconds        = seconds_r;
		pkt.sec.fraction       = fraction_r;
		pkt.sec.spare_msb      = 1'(`PEF_SPARE >> 3);
		pkt.sec.service_ver    = `PEF_SERVICE_VER;
		pkt.sec.checksum_flag  = `PEF_CHECKSUM_FLAG;
		pkt.sec.spare_lsb      = 3'(`PEF_SPARE & 4'h7);
		pkt.sec.service_type   = `PEF_SERVICE_TYPE;
		pkt.sec.subtype        = subtype_r;
		pkt.sec.pad            = `PEF_PAD;
		pkt.event_id           = kind_ast_r ? `PEF_EVID_ASTEROID : `PEF_EVID_POWERUP;
	end

	// next values of event sequencing, registers, bus answer and interrupt
	always_comb begin
		ctrl_nxt       = ctrl_r;
		irq_stat_nxt   = irq_stat_r;
		irq_mask_nxt   = irq_mask_r;
		subtype_nxt    = subtype_r;
		seconds_nxt    = seconds_r;
		fraction_nxt   = fraction_r;
		seq_nxt        = seq_r;
		pwr_sent_nxt   = pwr_sent_r;
		pulse_seen_nxt = pulse_seen_r | pulse_rise;
		ast_pend_nxt   = ast_pend_r;
		start_nxt      = 1'h0;
		kind_ast_nxt   = kind_ast_r;
		ack_nxt        = access;
		rdat_nxt       = 32'h0;
		irq_nxt        = 1'h0;
		// the asteroid start bit is one-shot; set by software, cleared here
		ctrl_nxt[`PEF_CTRL_AST_GO] = 1'h0;
		// register writes
		if (wr) begin
			case (wb_adr_i)
				`PEF_REG_CTRL: begin
					ctrl_nxt = (ctrl_r & ~wmask[3:0]) | (wb_dat_i[3:0] & wmask[3:0]);
				end
				`PEF_REG_IRQ_STAT: begin
					irq_stat_nxt = irq_stat_r & ~(wb_dat_i[2:0] & wmask[2:0]);
				end
				`PEF_REG_IRQ_MASK: begin
					irq_mask_nxt = (irq_mask_r & ~wmask[2:0]) | (wb_dat_i[2:0] & wmask[2:0]);
				end
				`PEF_REG_SUBTYPE: begin
					if (wb_sel_i[0]) subtype_nxt = wb_dat_i[7:0];
				end
				`PEF_REG_SECONDS: begin
					seconds_nxt = (seconds_r & ~wmask) | (wb_dat_i & wmask);
				end
				`PEF_REG_FRACTION: begin
					fraction_nxt = (fraction_r & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
				end
				default: begin
				end
			endcase
		end
		// asteroid sequence start request, held until a packet slot is free
		if (wr && wb_adr_i == `PEF_REG_CTRL && wb_sel_i[0] && wb_dat_i[`PEF_CTRL_AST_GO]) begin
			if (ast_pend_r) begin
				irq_stat_nxt[`PEF_IRQ_AST_DROP] = 1'h1; // second start while one waits
			end
			ast_pend_nxt = 1'h1;
		end
		// launch a packet when the serialiser is idle; powered-up has priority
		if (!ser_busy && !start_r && ctrl_r[`PEF_CTRL_ENABLE]) begin
			if (!pwr_sent_r && ctrl_r[`PEF_CTRL_BOOT_OK] && ctrl_r[`PEF_CTRL_SYNC_TC]
			    && pulse_seen_r) begin
				start_nxt    = 1'h1;
				kind_ast_nxt = 1'h0;
				pwr_sent_nxt = 1'h1;
			end else if (ast_pend_r) begin
				start_nxt    = 1'h1;
				kind_ast_nxt = 1'h1;
				ast_pend_nxt = 1'h0;                        // request consumed by this launch
				if (wr && wb_adr_i == `PEF_REG_CTRL && wb_sel_i[0]
				    && wb_dat_i[`PEF_CTRL_AST_GO]) begin
					ast_pend_nxt = 1'h1;                      // new request kept
				end
			end
		end
		// packet done: count it and raise its event; set wins over clear
		if (ser_done) begin
			seq_nxt = seq_r + 14'h0001;
			if (kind_ast_r) begin
				irq_stat_nxt[`PEF_IRQ_AST_DONE] = 1'h1;
			end else begin
				irq_stat_nxt[`PEF_IRQ_PWR_DONE] = 1'h1;
			end
		end
		// read data
		if (access && !wb_we_i) begin
			case (wb_adr_i)
				`PEF_REG_CTRL:     rdat_nxt = {28'h0, ctrl_r};
				`PEF_REG_STATUS:   rdat_nxt = {29'h0, pulse_seen_r & ~pwr_sent_r, pwr_sent_r,
				                               ser_busy | start_r};
				`PEF_REG_IRQ_STAT: rdat_nxt = {29'h0, irq_stat_r};
				`PEF_REG_IRQ_MASK: rdat_nxt = {29'h0, irq_mask_r};
				`PEF_REG_SEQ:      rdat_nxt = {18'h0, seq_r};
				`PEF_REG_SUBTYPE:  rdat_nxt = {24'h0, subtype_r};
				`PEF_REG_SECONDS:  rdat_nxt = seconds_r;
				`PEF_REG_FRACTION: rdat_nxt = {16'h0, fraction_r};
				default:           rdat_nxt = 32'h0;
			endcase
		end
		irq_nxt = |(irq_stat_nxt & irq_mask_nxt);
	end

	// register all state
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_r       <= 4'h0;
			irq_stat_r   <= 3'h0;
			irq_mask_r   <= 3'h0;
			subtype_r    <= `PEF_SUBTYPE_DEF;
			seconds_r    <= 32'h0;
			fraction_r   <= 16'h0;
			seq_r        <= `PEF_SEQ_RESET;
			pwr_sent_r   <= 1'h0;
			pulse_seen_r <= 1'h0;
			ast_pend_r   <= 1'h0;
			start_r      <= 1'h0;
			kind_ast_r   <= 1'h0;
			ack_r        <= 1'h0;
			rdat_r       <= 32'h0;
			irq_r        <= 1'h0;
		end else begin
			ctrl_r       <= ctrl_nxt;
			irq_stat_r   <= irq_stat_nxt;
			irq_mask_r   <= irq_mask_nxt;
			subtype_r    <= subtype_nxt;
			seconds_r    <= seconds_nxt;
			fraction_r   <= fraction_nxt;
			seq_r        <= seq_nxt;
			pwr_sent_r   <= pwr_sent_nxt;
			pulse_seen_r <= pulse_seen_nxt;
			ast_pend_r   <= ast_pend_nxt;
			start_r      <= start_nxt;
			kind_ast_r   <= kind_ast_nxt;
			ack_r        <= ack_nxt;
			rdat_r       <= rdat_nxt;
			irq_r        <= irq_nxt;
		end
	end

	// byte stream serialiser
	pef_byte_ser u_ser (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.start_i (start_r),
		.pkt_i   (pkt),
		.busy_o  (ser_busy),
		.done_o  (ser_done),
		.data_o  (ser_data),
		.valid_o (ser_valid),
		.last_o  (ser_last),
		.ready_i (tm_ready_i)
	);

	// outputs from flip-flops
	assign wb_ack_o   = ack_r;
	assign wb_dat_o   = rdat_r;
	assign irq_o      = irq_r;
	assign tm_data_o  = ser_data;
	assign tm_valid_o = ser_valid;
	assign tm_last_o  = ser_last;

endmodule

// ==== sim/pef_framer_sva.sv ====
/*
 * Checker of the framer's register bus answer and telemetry byte stream.
 * Assumes binding to pef_framer, one clock, synchronous active-high reset.
 */
`timescale 1ns/1ns

module pef_framer_sva (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic [7:0]  tm_data_o,
	input wire logic        tm_valid_o,
	input wire logic        tm_last_o,
	input wire logic        tm_ready_i
);
	logic [4:0] idx_r;
	logic [4:0] idx_nxt;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// position of the current byte within its packet
	always_comb begin
		idx_nxt = idx_r;
		if (tm_valid_o && tm_ready_i)
			idx_nxt = tm_last_o ? 5'h00 : idx_r + 5'h01;
	end

	// register the position; a packet always starts at byte zero
	always_ff @(posedge clk_i) begin
		idx_r <= rst_i ? 5'h00 : idx_nxt;
	end

	ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("bus request not answered next cycle");
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");
	dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("read data driven without ack");
	byte_hold_a: assert property (tm_valid_o && !tm_ready_i |=> tm_valid_o && $stable(tm_data_o))
		else $error("stalled byte changed or dropped");
	apid_byte_a: assert property (tm_valid_o && idx_r < 5'h02 |->
		tm_data_o == (idx_r == 5'h00 ? 8'h0C : 8'h77)) else $error("identifier bytes wrong");
	seg_flag_a: assert property (tm_valid_o && idx_r == 5'h02 |-> tm_data_o[7:6] == 2'h3)
		else $error("segmentation flags wrong");
	length_byte_a: assert property (tm_valid_o && idx_r inside {5'h04, 5'h05} |->
		tm_data_o == (idx_r == 5'h04 ? 8'h00 : 8'h0B)) else $error("length field wrong");
	fixed_sec_a: assert property (tm_valid_o && idx_r inside {5'h0C, 5'h0D, 5'h0F} |->
		tm_data_o == (idx_r == 5'h0C ? 8'h20 : idx_r == 5'h0D ? 8'h05 : 8'h00))
		else $error("secondary header constant wrong");
	event_id_a: assert property (tm_valid_o && idx_r >= 5'h10 |->
		(idx_r == 5'h10 ? tm_data_o == 8'hA7 : tm_data_o[7:1] == 7'h7F))
		else $error("event identifier wrong");
	last_place_a: assert property (tm_valid_o |-> tm_last_o == (idx_r == 5'h11))
		else $error("last flag not on eighteenth byte");
	pkt_gap_a: assert property (tm_valid_o && tm_ready_i && tm_last_o |=> !tm_valid_o)
		else $error("no gap after packet");
endmodule

bind pef_framer pef_framer_sva u_sva (
	.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .tm_data_o(tm_data_o),
	.tm_valid_o(tm_valid_o), .tm_last_o(tm_last_o), .tm_ready_i(tm_ready_i)
);

// ==== sim/pef_tm_sink.sv ====
/*
 * Telemetry link sink model: accepts bytes with random back-pressure.
 * Assumes the bench clock and reset; the seed is set by the bench.
 */
`timescale 1ns/1ns

module pef_tm_sink (
	input  wire logic clk_i,
	input  wire logic rst_i,
	output logic      ready_o
);
	initial ready_o = 1'b0;

	// ready roughly three cycles in four, so stalls land mid-packet
	always @(posedge clk_i) begin
		ready_o <= !rst_i && ($urandom_range(3) != 0);
	end
endmodule

// ==== sim/tb.sv ====
/*
 * Self-checking bench of the progress event packet framer.
 * Assumes the framer, its checker bind and the sink model are compiled first.
 */
`timescale 1ns/1ns
`include "pef_map.svh"

module tb;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        cyc, stb, we, tsp, ack, tv, tl, trdy, irq;
	logic [7:0]  adr, td, st_v;
	logic [3:0]  sel;
	logic [31:0] wdat, rdat, rd_v, sec_v;
	logic [15:0] frac_v;
	logic [8:0]  exp_q[$];
	int          n_mismatch = 0;
	int          total_checks = 0;

	always #50 clk_i = ~clk_i;

	pef_framer u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .time_sync_pulse_i(tsp), .tm_data_o(td), .tm_valid_o(tv),
		.tm_last_o(tl), .tm_ready_i(trdy), .irq_o(irq));
	pef_tm_sink u_sink (.clk_i(clk_i), .rst_i(rst_i), .ready_o(trdy));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
			n_mismatch++;
		end
	endtask

	// one classic cycle, entered and left at a rising edge
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int t;
		t = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do begin
			@(posedge clk_i);
			t++;
		end while (ack !== 1'b1 && t < 50);
		rd_v = rdat;
		chk(32'(ack), 32'h1);
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		@(posedge clk_i);
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0);
		chk(rd_v, e);
	endtask

	// header 0C77: version 0, type 0, flag 1, identifier 71, category 7
	task automatic exp_pkt(input logic [13:0] sq, input logic [15:0] id);
		logic [143:0] p;
		p = {16'h0C77, 2'h3, sq, 16'h000B, sec_v, frac_v, 16'h2005, st_v, 8'h00, id};
		for (int i = 17; i >= 0; i--)
			exp_q.push_back({i == 0, p[i*8 +: 8]});
	endtask

	task automatic drain;
		int t;
		t = 0;
		while (exp_q.size() != 0 && t < 3000) begin
			@(posedge clk_i);
			t++;
		end
		repeat (4) @(posedge clk_i);
		chk(32'(exp_q.size()), 32'h0);
	endtask

	// sync pulse long enough for the two-flop synchroniser
	task automatic pulse;
		tsp <= 1'b1;
		repeat (3) @(posedge clk_i);
		tsp <= 1'b0;
		repeat (40) @(posedge clk_i);
	endtask

	task automatic stamp;
		sec_v = $urandom;
		frac_v = 16'($urandom);
		wb(1'b1, `PEF_REG_SECONDS, sec_v);
		wb(1'b1, `PEF_REG_FRACTION, {16'h0000, frac_v});
	endtask

	task automatic conclude;
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// compare each accepted byte with the oldest note
	always @(posedge clk_i) begin
		if (!rst_i && tv === 1'b1 && trdy === 1'b1) begin
			if (exp_q.size() == 0)
				chk(32'({tl, td}), 32'h200);
			else
				chk(32'({tl, td}), 32'(exp_q.pop_front()));
		end
	end

	// cut a hang short
	initial begin
		repeat (6000) @(posedge clk_i);
		n_mismatch++;
		conclude;
	end

	initial begin
		{cyc, stb, we, tsp} = 4'h0;
		adr = 8'h00;
		sel = 4'hF;
		wdat = 32'h0;
		void'($urandom(32'h1E65));
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		rdc(`PEF_REG_SUBTYPE, 32'h1);
		rdc(`PEF_REG_SEQ, 32'h0);
		rdc(`PEF_REG_STATUS, 32'h0);
		wb(1'b1, 8'h40, $urandom);
		rdc(8'h40, 32'h0);
		wb(1'b1, `PEF_REG_IRQ_MASK, 32'h7);
		rdc(`PEF_REG_IRQ_MASK, 32'h7);
		st_v = 8'h01;
		stamp;
		// pulse with boot done but no sync command: nothing goes out
		wb(1'b1, `PEF_REG_CTRL, 32'h9);
		pulse;
		rdc(`PEF_REG_STATUS, 32'h4);
		exp_pkt(14'h0000, 16'hA7FE);
		wb(1'b1, `PEF_REG_CTRL, 32'hB);
		drain;
		chk(32'(irq), 32'h1);
		rdc(`PEF_REG_IRQ_STAT, 32'h1);
		wb(1'b1, `PEF_REG_IRQ_STAT, 32'h1);
		rdc(`PEF_REG_IRQ_STAT, 32'h0);
		chk(32'(irq), 32'h0);
		rdc(`PEF_REG_STATUS, 32'h2);
		pulse;
		// asteroid packets, second one with its interrupt masked
		for (int k = 0; k < 2; k++) begin
			st_v = 8'($urandom);
			wb(1'b1, `PEF_REG_SUBTYPE, {24'h0, st_v});
			stamp;
			wb(1'b1, `PEF_REG_IRQ_MASK, k == 0 ? 32'h7 : 32'h1);
			exp_pkt(14'(k + 1), 16'hA7FF);
			wb(1'b1, `PEF_REG_CTRL, 32'hF);
			drain;
			rdc(`PEF_REG_SEQ, 32'(k + 2));
			rdc(`PEF_REG_IRQ_STAT, 32'h2);
			chk(32'(irq), 32'(k == 0));
			wb(1'b1, `PEF_REG_IRQ_STAT, 32'h2);
			rdc(`PEF_REG_IRQ_STAT, 32'h0);
		end
		// two start requests while sending is off: the second is flagged, one packet follows
		wb(1'b1, `PEF_REG_CTRL, 32'h7);
		wb(1'b1, `PEF_REG_CTRL, 32'h7);
		rdc(`PEF_REG_IRQ_STAT, 32'h4);
		wb(1'b1, `PEF_REG_IRQ_STAT, 32'h4);
		rdc(`PEF_REG_IRQ_STAT, 32'h0);
		exp_pkt(14'h0003, 16'hA7FF);
		wb(1'b1, `PEF_REG_CTRL, 32'hB);
		drain;
		rdc(`PEF_REG_SEQ, 32'h4);
		rdc(`PEF_REG_IRQ_STAT, 32'h2);
		conclude;
	end
endmodule
